// [verification/serial_peer.sv]
// Far-side serial device: frames words onto the receive line and
// captures frames from the transmit line. Assumes 16 clocks per bit.
`timescale 1ns/1ps
module serial_peer (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out,
    output logic [9:0] got_q,
    output logic got_new
);
    int i;

    initial line_out = 1'b1;
    initial got_new = 1'b0;
    initial got_q = 10'h000;

    // One bit time, then step off the edge
    task automatic bit_wait;
        repeat (16) @(posedge clk);
        #1;
    endtask

    // Start, n data bits, one stop of chosen level, then rest high
    task automatic send(input logic [8:0] w, input int n, input logic stop);
        int b;
        line_out = 1'b0;
        bit_wait();
        for (b = 0; b < n; b++) begin
            line_out = w[b];
            bit_wait();
        end
        // Stop level over the sampling point only, so a low stop bit
        // does not run on into what looks like a fresh start bit
        line_out = stop;
        repeat (12) @(posedge clk);
        #1;
        line_out = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        bit_wait();
    endtask

    // Capture ten mid-bit samples after a start bit
    initial forever begin
        @(negedge line_in);
        repeat (8) @(posedge clk);
        if (line_in == 1'b0) begin
            for (i = 0; i < 10; i++) begin
                repeat (16) @(posedge clk);
                got_q[i] = line_in;
            end
            got_new = ~got_new;
        end
    end
endmodule

// [verification/uart_status_and_frame_control_tb.sv]
// Self-checking bench of the serial status and frame control block.
// Assumes serial_peer on the pins and a divisor of zero.
`timescale 1ns/1ps
module uart_status_and_frame_control_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_sel = 2'h0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic receive_pin;
    logic transmit_pin;
    logic transmit_pin_oe;
    logic rx_irq;
    logic [9:0] got_q;
    logic got_new;
    logic tx_line;
    logic [7:0] v;
    logic [3:0] par = 4'h6;
    int miscompares = 0;
    int checks = 0;
    int k;
    int lows;

    // Pull-up holds the line high while the pin floats
    assign tx_line = transmit_pin_oe ? transmit_pin : 1'b1;

    always #12.5 clk = ~clk;

    uart_status_and_frame_control dut_u (
        .clk(clk),
        .rst(rst),
        .reg_sel(reg_sel),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .baud_div(16'h0000),
        .receive_pin(receive_pin),
        .transmit_pin(transmit_pin),
        .transmit_pin_oe(transmit_pin_oe),
        .rx_irq(rx_irq)
    );

    serial_peer peer_u (
        .clk(clk),
        .line_in(tx_line),
        .line_out(receive_pin),
        .got_q(got_q),
        .got_new(got_new)
    );

    // Compare and count
    task automatic chk(input string n, input logic [9:0] e,
                       input logic [9:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // One write strobe, then a quiet cycle
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // One read strobe; data is taken a cycle later
    task automatic rd(input logic [1:0] s);
        reg_sel = s;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        @(posedge clk);
        #1;
        v = reg_rdata;
    endtask

    task automatic rdchk(input logic [1:0] s, input logic [7:0] e,
                         input string n);
        rd(s);
        chk(n, {2'b00, e}, {2'b00, v});
    endtask

    // Arm with a status read, load the data register, await the frame
    task automatic xmit(input logic [7:0] d);
        rd(2'h0);
        wr(2'h3, d);
        @(got_new);
        repeat (24) @(posedge clk);
        #1;
    endtask

    task automatic summarize;
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 30000);
        miscompares++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        rdchk(2'h0, 8'h0B, "status");
        wr(2'h0, 8'hFF);
        rdchk(2'h0, 8'h0B, "status");
        wr(2'h1, 8'h80);
        wr(2'h2, 8'hC4);
        rdchk(2'h0, 8'h0B, "status");
        // Plain frame, then every parity type in bit 7
        for (k = 0; k < 5; k++) begin
            if (k > 0) wr(2'h1, 8'hA0 | 8'((k - 1) << 3));
            xmit(8'hB5);
            chk("frame", {2'b01, k == 0 ? 1'b1 : par[k-1], 7'h35},
                {1'b0, got_q[8:0]});
            rdchk(2'h0, 8'h0B, "status");
        end
        // Good word, framing error, parity error
        wr(2'h1, 8'h80);
        peer_u.send(9'h05A, 8, 1'b1);
        chk("irq", 10'h001, {9'h000, rx_irq});
        rdchk(2'h0, 8'h0F, "status");
        rdchk(2'h3, 8'h5A, "data");
        rdchk(2'h0, 8'h0B, "status");
        peer_u.send(9'h033, 8, 1'b0);
        rdchk(2'h0, 8'h2F, "status");
        rdchk(2'h3, 8'h33, "data");
        rdchk(2'h0, 8'h0B, "status");
        wr(2'h1, 8'hA0);
        peer_u.send(9'h001, 8, 1'b1);
        rdchk(2'h0, 8'h8F, "status");
        rdchk(2'h3, 8'h01, "data");
        rdchk(2'h0, 8'h0B, "status");
        // Five words into a four-deep buffer
        wr(2'h1, 8'h80);
        for (k = 1; k < 6; k++) peer_u.send(9'(k * 17), 8, 1'b1);
        rdchk(2'h0, 8'h1F, "status");
        // Unit off mid-state, then on again
        wr(2'h1, 8'h00);
        rdchk(2'h0, 8'h0B, "status");
        rdchk(2'h2, 8'h04, "ctrl2");
        chk("oe", 10'h000, {9'h000, transmit_pin_oe});
        chk("irq", 10'h000, {9'h000, rx_irq});
        wr(2'h1, 8'h80);
        rdchk(2'h1, 8'h80, "ctrl1");
        // Nine-bit frames both ways
        wr(2'h2, 8'hC0);
        wr(2'h1, 8'hC1);
        xmit(8'h00);
        chk("frame9", 10'h300, got_q);
        peer_u.send(9'h1C3, 9, 1'b1);
        rdchk(2'h1, 8'hC2, "ctrl1");
        rdchk(2'h3, 8'hC3, "data");
        // Break holds the line low for thirteen bit times
        wr(2'h1, 8'h84);
        repeat (20) @(posedge clk);
        #1;
        lows = 0;
        for (k = 0; k < 208; k++) begin
            lows += (tx_line === 1'b0);
            @(posedge clk);
            #1;
        end
        chk("break", 10'h0D0, 10'(lows));
        wr(2'h1, 8'h80);
        repeat (20) @(posedge clk);
        #1;
        chk("break end", 10'h001, {9'h000, tx_line});
        // Short break request still lasts thirteen bit times
        wr(2'h1, 8'h84);
        wr(2'h1, 8'h80);
        lows = 0;
        for (k = 0; k < 240; k++) begin
            lows += (tx_line === 1'b0);
            @(posedge clk);
            #1;
        end
        chk("break min", 10'h001, {9'h000, lows >= 208});
        chk("line idle", 10'h001, {9'h000, tx_line});
        summarize();
    end
endmodule

// [verilog/uart_baud_tick.sv]
// Rate divider giving a one-cycle tick every div+1 clocks.
// Assumes div is steady while run is high; run low clears the count.
`timescale 1ns/1ps
module uart_baud_tick #(
    parameter int W = 16
) (
    input logic clk,
    input logic rst,
    input logic run,
    input logic [W-1:0] div,
    output logic tick
);
    logic [W-1:0] cnt_q;

    // Count up to div, pulse, wrap
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick <= 1'b0;
        end
    end
endmodule

// [verilog/uart_cfg.svh]
// Offsets, field positions, reset values and bit-time counts of the
// serial status and frame control block. Definitions only.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// Register select codes on the CPU register port
`define REG_STATUS 2'h0
`define REG_CTRL1 2'h1
`define REG_CTRL2 2'h2
`define REG_DATA 2'h3

// Second control register field positions
`define C2_TXEN 7
`define C2_RXEN 6

// Reset values
`define CTRL1_RST 7'h00
`define CTRL2_RST 8'h00
`define FLAG_CLR 1'b0
`define FLAG_SET 1'b1
`define LINE_IDLE 12'hFFF

// Parity type codes
`define PAR_EVEN 2'h0
`define PAR_ODD 2'h1
`define PAR_MARK 2'h2

// Oversampling: sixteen ticks per bit, three samples mid-bit
`define OS_LAST 4'hF
`define SMP_FIRST 4'h7
`define SMP_LAST 4'h9

// Frame lengths in bit times
`define DATA8 4'h8
`define DATA9 4'h9
`define HEAD8 4'h9
`define HEAD9 4'hA
`define STOP1 4'h1
`define STOP2 4'h2
`define BREAK_BITS 4'hD

`endif

// [verilog/uart_pkg.sv]
// Types shared by the serial status and frame control block.
// Assumes the including files take constants from uart_cfg.svh.
package uart_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

    // First control register, ninth received bit excluded
    typedef struct packed {
        logic unit_en;
        logic len9;
        logic par_en;
        logic [1:0] par_type;
        logic brk;
        logic tx9;
    } ctrl1_t;

    // Second control register
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic stops;
        logic addr_en;
        logic wake;
        logic rie;
        logic tiie;
        logic teie;
    } ctrl2_t;

endpackage

// [verilog/uart_status_and_frame_control.sv]
// Status flags, first control register and frame engines of a serial unit.
// Assumes a CPU port with one-cycle read and write strobes and a
// sixteen-times-bit-rate divisor supplied from outside.
`timescale 1ns/1ps
`include "uart_cfg.svh"
// Behaviour
// - Status flags are read only; status writes change nothing.
// - With parity on, a parity mismatch sets the parity error flag.
// - Parity error clears on status read then data access.
// - Noise flag sets with data available, never on an overrun.
// - Framing error sets on bad stop; clears on read-then-access.
// - Overflow sets overrun and blocks further stores until cleared.
// - Receiver idle is low from start detect to stop completion.
// - Data available sets at trigger level with that word's errors.
// - Data available clears after status read, data read, empty buffer.
// - Transmitter idle sets when empty and nothing sent; line high.
// - Transmitter idle clears on status read then data write.
// - Transmit empty sets on move to shifter; clears read-then-write.
// - Turning the transmitter on sets transmit empty.
// - Unit off floats pins, drops buffers, resets the rate counter.
// - Unit off clears enables, break, data flags; sets idle flags.
// - Unit off aborts transfers; on again keeps settings, but transmit and receive enables stay off.
// - Length bit picks 8 or 9 data bits; ninth bits stored.
// - Parity takes the top data bit and is not stored on receive.
// - Parity type: even, odd, constant one, constant zero.
// - Break drives low after buffered data, at least 13 bit times.
// - Received ninth bit read only; transmitted ninth write only.
// - Characters go out and come in least significant bit first.
// - One stop bit or two, by the stop select bit.
module uart_status_and_frame_control #(
    parameter int FIFO_DEPTH = 4,
    parameter int RX_TRIGGER = 1,
    parameter int DIV_W = 16
) (
    input logic clk,
    input logic rst,
    input logic [1:0] reg_sel,
    input logic reg_rd,
    input logic reg_wr,
    input logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input logic [DIV_W-1:0] baud_div,
    input logic receive_pin,
    output logic transmit_pin,
    output logic transmit_pin_oe,
    output logic rx_irq
);
    localparam int PW = $clog2(FIFO_DEPTH);

    uart_pkg::ctrl1_t c1_q;
    uart_pkg::ctrl2_t c2_q;
    uart_pkg::tx_state_t tx_st_q;
    uart_pkg::rx_state_t rx_st_q;
    logic perr_q, nf_q, fe_q, oe_q, rxif_q, tidle_q, txif_q;
    logic armed_q, seen_rxif_q, seen_txif_q, seen_tidle_q;
    logic [7:0] tx_buf_q;
    logic tx_full_q;
    logic [11:0] tx_sh_q, tx_frame;
    logic [3:0] tx_bits_q, tx_os_q, tx_len;
    logic [8:0] rx_sh_q, rx_word;
    logic [3:0] rx_os_q, rx_idx_q, nbits;
    logic [2:0] smp_q;
    logic nacc_q;
    logic [8:0] fifo_q [FIFO_DEPTH];
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q, cnt_d;
    logic tick, active, st_rd, dat_rd, dat_wr, dat_acc, seq_clr;
    logic txen_set, move, tx_par, bit_end, rx_bit, rx_noisy;
    logic rx_done, rx_pe, full, push, pop, ridle;
    logic [7:0] status;

    function automatic logic par_bit(input logic [1:0] t,
                                     input logic [7:0] d);
        case (t)
            `PAR_EVEN: par_bit = ^d;
            `PAR_ODD: par_bit = ~^d;
            `PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // Shared rate divider, held clear while the unit is off
    uart_baud_tick #(.W(DIV_W)) u_tick (
        .clk(clk),
        .rst(rst),
        .run(active),
        .div(baud_div),
        .tick(tick)
    );

    // Access decode
    assign active = c1_q.unit_en;
    assign st_rd = reg_rd && reg_sel == `REG_STATUS;
    assign dat_rd = reg_rd && reg_sel == `REG_DATA;
    assign dat_wr = reg_wr && reg_sel == `REG_DATA;
    assign dat_acc = dat_rd || dat_wr;
    assign seq_clr = armed_q && dat_acc;
    assign txen_set = reg_wr && reg_sel == `REG_CTRL2 && active
                      && reg_wdata[`C2_TXEN] && !c2_q.tx_en;
    assign nbits = c1_q.len9 ? `DATA9 : `DATA8;
    assign ridle = rx_st_q == uart_pkg::RX_IDLE;
    assign status = {perr_q, nf_q, fe_q, oe_q, ridle, rxif_q, tidle_q,
                     txif_q};
    assign rx_irq = c2_q.rie && (rxif_q || oe_q);

    // Transmit frame: start low, data LSB first, parity on top, stops high
    assign tx_par = par_bit(c1_q.par_type, c1_q.len9 ? tx_buf_q
                            : {1'b0, tx_buf_q[6:0]});
    always_comb begin
        if (c1_q.len9) begin
            tx_frame = {2'b11, c1_q.par_en ? tx_par : c1_q.tx9, tx_buf_q,
                        1'b0};
            tx_len = `HEAD9 + (c2_q.stops ? `STOP2 : `STOP1);
        end else begin
            tx_frame = {3'b111, c1_q.par_en ? tx_par : tx_buf_q[7],
                        tx_buf_q[6:0], 1'b0};
            tx_len = `HEAD8 + (c2_q.stops ? `STOP2 : `STOP1);
        end
    end

    // Receive decode: majority of three samples, noise on disagreement
    assign bit_end = tick && rx_os_q == `OS_LAST;
    assign rx_bit = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2])
                    | (smp_q[0] & smp_q[2]);
    assign rx_noisy = !(&smp_q) && (|smp_q);
    assign rx_done = rx_st_q == uart_pkg::RX_BITS && bit_end
                     && rx_idx_q == nbits;
    assign rx_pe = c1_q.par_en && rx_sh_q[8] != par_bit(c1_q.par_type,
                   c1_q.len9 ? rx_sh_q[7:0] : {1'b0, rx_sh_q[7:1]});
    assign rx_word = c1_q.len9 ? {rx_sh_q[8] & !c1_q.par_en, rx_sh_q[7:0]}
                   : {1'b0, rx_sh_q[8] & !c1_q.par_en, rx_sh_q[7:1]};
    assign full = cnt_q == (PW+1)'(FIFO_DEPTH);
    assign push = rx_done && !full && !oe_q;
    assign pop = dat_rd && cnt_q != '0;
    assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    assign move = tx_st_q == uart_pkg::TX_IDLE && tx_full_q && active
                  && c2_q.tx_en;

    // Register read port, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_sel)
                `REG_STATUS: reg_rdata <= status;
                `REG_CTRL1: reg_rdata <= {c1_q[6:1], fifo_q[rp_q][8],
                                          1'b0};
                `REG_CTRL2: reg_rdata <= c2_q;
                default: reg_rdata <= fifo_q[rp_q][7:0];
            endcase
        end
    end

    // First control register; status writes fall through untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            c1_q <= `CTRL1_RST;
        end else if (reg_wr && reg_sel == `REG_CTRL1) begin
            c1_q <= {reg_wdata[7:3], reg_wdata[2] & reg_wdata[7],
                     reg_wdata[0]};
        end else if (!active) begin
            c1_q.brk <= 1'b0;
        end
    end

    // Second control register; enables drop while the unit is off
    always_ff @(posedge clk) begin
        if (rst) begin
            c2_q <= `CTRL2_RST;
        end else if (!active) begin
            c2_q.tx_en <= 1'b0;
            c2_q.rx_en <= 1'b0;
        end else if (reg_wr && reg_sel == `REG_CTRL2) begin
            c2_q <= reg_wdata;
        end
    end

    // Read-then-access sequence tracker
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            armed_q <= 1'b0;
            seen_rxif_q <= 1'b0;
            seen_txif_q <= 1'b0;
            seen_tidle_q <= 1'b0;
        end else if (st_rd) begin
            armed_q <= 1'b1;
            seen_rxif_q <= rxif_q;
            seen_txif_q <= txif_q;
            seen_tidle_q <= tidle_q;
        end else if (dat_acc) begin
            armed_q <= 1'b0;
        end
    end

    // Receive error flags; a new error beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            {perr_q, nf_q, fe_q, oe_q} <= 4'h0;
        end else begin
            if (seq_clr)
                {perr_q, nf_q, fe_q, oe_q} <= 4'h0;
            if (push && rx_pe)
                perr_q <= 1'b1;
            if (push && (nacc_q || rx_noisy))
                nf_q <= 1'b1;
            if (push && !rx_bit)
                fe_q <= 1'b1;
            if (rx_done && full)
                oe_q <= 1'b1;
        end
    end

    // Data available flag
    always_ff @(posedge clk) begin
        if (rst || !active)
            rxif_q <= `FLAG_CLR;
        else if (push && cnt_d >= (PW+1)'(RX_TRIGGER))
            rxif_q <= `FLAG_SET;
        else if (seq_clr && seen_rxif_q && dat_rd && cnt_d == '0)
            rxif_q <= `FLAG_CLR;
    end

    // Transmit empty and transmitter idle flags
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            txif_q <= `FLAG_SET;
            tidle_q <= `FLAG_SET;
        end else begin
            if (seq_clr && dat_wr && seen_txif_q)
                txif_q <= `FLAG_CLR;
            if (move || txen_set)
                txif_q <= `FLAG_SET;
            if (seq_clr && dat_wr && seen_tidle_q)
                tidle_q <= `FLAG_CLR;
            if (txif_q && tx_st_q == uart_pkg::TX_IDLE && !tx_full_q
                && !c1_q.brk && !dat_wr)
                tidle_q <= `FLAG_SET;
        end
    end

    // One-byte transmit buffer, emptied when the unit or sender is off
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_q <= 8'h00;
            tx_full_q <= 1'b0;
        end else if (!active || !c2_q.tx_en) begin
            tx_full_q <= 1'b0;
        end else if (dat_wr) begin
            tx_buf_q <= reg_wdata;
            tx_full_q <= 1'b1;
        end else if (move) begin
            tx_full_q <= 1'b0;
        end
    end

    // Transmit engine: frames, then break once the buffer is empty
    always_ff @(posedge clk) begin
        if (rst || !active || !c2_q.tx_en) begin
            tx_st_q <= uart_pkg::TX_IDLE;
            tx_sh_q <= `LINE_IDLE;
            tx_bits_q <= 4'h0;
            tx_os_q <= 4'h0;
        end else begin
            case (tx_st_q)
                uart_pkg::TX_IDLE: begin
                    tx_os_q <= 4'h0;
                    if (move) begin
                        tx_sh_q <= tx_frame;
                        tx_bits_q <= tx_len;
                        tx_st_q <= uart_pkg::TX_SHIFT;
                    end else if (c1_q.brk) begin
                        tx_sh_q <= 12'h000;
                        tx_bits_q <= 4'h0;
                        tx_st_q <= uart_pkg::TX_BREAK;
                    end
                end
                uart_pkg::TX_SHIFT: if (tick) begin
                    tx_os_q <= tx_os_q + 4'h1;
                    if (tx_os_q == `OS_LAST) begin
                        tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                        tx_bits_q <= tx_bits_q - 4'h1;
                        if (tx_bits_q == 4'h1)
                            tx_st_q <= uart_pkg::TX_IDLE;
                    end
                end
                uart_pkg::TX_BREAK: if (tick) begin
                    tx_os_q <= tx_os_q + 4'h1;
                    if (tx_os_q == `OS_LAST) begin
                        if (tx_bits_q != `BREAK_BITS) begin
                            tx_bits_q <= tx_bits_q + 4'h1;
                        end else if (!c1_q.brk) begin
                            tx_sh_q <= `LINE_IDLE;
                            tx_st_q <= uart_pkg::TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= uart_pkg::TX_IDLE;
            endcase
        end
    end

    // Pins float unless unit and transmitter are on
    assign transmit_pin = tx_sh_q[0];
    assign transmit_pin_oe = active && c2_q.tx_en;

    // Receive engine: sixteen ticks per bit, samples mid-bit
    always_ff @(posedge clk) begin
        if (rst || !active || !c2_q.rx_en) begin
            rx_st_q <= uart_pkg::RX_IDLE;
            rx_os_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            smp_q <= 3'h7;
            nacc_q <= 1'b0;
        end else begin
            case (rx_st_q)
                uart_pkg::RX_IDLE: begin
                    rx_os_q <= 4'h0;
                    if (!receive_pin)
                        rx_st_q <= uart_pkg::RX_START;
                end
                uart_pkg::RX_START, uart_pkg::RX_BITS: if (tick) begin
                    rx_os_q <= rx_os_q + 4'h1;
                    if (rx_os_q >= `SMP_FIRST && rx_os_q <= `SMP_LAST)
                        smp_q <= {smp_q[1:0], receive_pin};
                    if (rx_os_q == `OS_LAST) begin
                        if (rx_st_q == uart_pkg::RX_START) begin
                            nacc_q <= rx_noisy;
                            rx_idx_q <= 4'h0;
                            rx_st_q <= rx_bit ? uart_pkg::RX_IDLE
                                     : uart_pkg::RX_BITS;
                        end else if (rx_idx_q == nbits) begin
                            rx_st_q <= uart_pkg::RX_IDLE;
                        end else begin
                            rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
                            rx_idx_q <= rx_idx_q + 4'h1;
                            nacc_q <= nacc_q | rx_noisy;
                        end
                    end
                end
                default: rx_st_q <= uart_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive buffer pointers and fill count
    always_ff @(posedge clk) begin
        if (rst || !active || !c2_q.rx_en) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push)
                wp_q <= wp_q + PW'(1);
            if (pop)
                rp_q <= rp_q + PW'(1);
            cnt_q <= cnt_d;
        end
    end

    // Receive buffer storage, ninth bit kept per word
    always_ff @(posedge clk) begin
        if (push)
            fifo_q[wp_q] <= rx_word;
    end

    chk_unit_off_flags: assert property (@(posedge clk) disable iff (rst)
        !active |=> txif_q && tidle_q && !rxif_q && !oe_q && !perr_q)
        else $error("flags not reset while unit off");
    chk_pin_float: assert property (@(posedge clk) disable iff (rst)
        !active |-> !transmit_pin_oe)
        else $error("transmit pin driven while unit off");
    chk_break_low: assert property (@(posedge clk) disable iff (rst)
        tx_st_q == uart_pkg::TX_BREAK |-> !transmit_pin)
        else $error("line not low during break");
    chk_break_min: assert property (@(posedge clk) disable iff (rst)
        tx_st_q == uart_pkg::TX_BREAK && tx_bits_q < 4'hD && active
        && c2_q.tx_en |=> tx_st_q == uart_pkg::TX_BREAK)
        else $error("break ended before thirteen bit times");
    chk_idle_line_high: assert property (@(posedge clk) disable iff (rst)
        tx_st_q == uart_pkg::TX_IDLE && active |-> transmit_pin)
        else $error("line not high while transmitter idle");
    chk_txen_empty: assert property (@(posedge clk) disable iff (rst)
        txen_set |=> txif_q)
        else $error("transmit empty not set on enable");
    chk_move_empty: assert property (@(posedge clk) disable iff (rst)
        move ##1 active |-> txif_q ##0
        tx_st_q == uart_pkg::TX_SHIFT)
        else $error("move did not set empty or start frame");
    chk_tidle_clear: assert property (@(posedge clk) disable iff (rst)
        seq_clr && dat_wr && seen_tidle_q && active |=> !tidle_q)
        else $error("transmitter idle kept after clear sequence");
    chk_overrun_block: assert property (@(posedge clk) disable iff (rst)
        oe_q |-> !push)
        else $error("store while overrun pending");
    chk_noise_overrun: assert property (@(posedge clk) disable iff (rst)
        rx_done && full && active
        |=> nf_q == ($past(nf_q) && !$past(seq_clr)))
        else $error("noise flag changed on overrun");
    chk_rxif_trigger: assert property (@(posedge clk) disable iff (rst)
        push && cnt_d >= (PW+1)'(RX_TRIGGER) && active
        |=> rxif_q && (perr_q || !$past(rx_pe)))
        else $error("data available or error late");
    chk_seq_clear: assert property (@(posedge clk) disable iff (rst)
        seq_clr && !push |=> !perr_q && !nf_q && !fe_q
        && (!oe_q || $past(rx_done)))
        else $error("error flags kept after clear sequence");
    chk_rx_busy: assert property (@(posedge clk) disable iff (rst)
        rx_st_q == uart_pkg::RX_IDLE && active && c2_q.rx_en
        && !receive_pin |=> !status[3])
        else $error("receiver idle after start detect");
endmodule
